/* pin_model.sv */
// Board-side model that drives the timer pins of the block.
`timescale 1ns/1ps
module pin_model (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire tt_pkg::pin_in_t want,
	output tt_pkg::pin_in_t      pins
);
	import tt_pkg::*;
	// Idle pins sit high as with pull-ups, so the first low is an edge.
	// Levels move only just after an edge, never inside the sample step.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pins <= '1;
		else
			pins <= want;
	end
endmodule : pin_model

/* triple_timer_counter_baud.sv */
// Three timer/counters with capture, reload, baud ticks and clock output.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tt_map.svh"

// Functional notes
// - third timer overflow flag sets on overflow, never while a serial clock select is 1.
// - external flag sets when an enabled trigger falling edge captures or reloads.
// - in up/down mode the external flag does not request an interrupt.
// - serial receive/transmit ticks come from third timer when selected, else second timer.
// - receive and transmit clock selections act independently.
// - trigger enable at 0 makes trigger edges ignored; up/down mode still reads the pin level for direction.
// - count select 0 counts machine cycles (half-oscillator clocks for the third timer in baud or clock-out mode), 1 counts count pin events.
// - capture select chooses capture or reload; serial clock selects force reload.
// - third timer mode from run, clock selects, capture select and down enable.
// - legacy mode 0 is a 13-bit counter; rollover sets its overflow flag.
// - legacy timer counts when run and (gate 0 or external interrupt pin high).
// - legacy mode 1 is mode 0 with all 16 bits.
// - legacy mode 2 counts low byte, reloads it from high byte on overflow.
// - second timer in mode 3 holds its count.
// - first timer mode 3 splits; high byte uses second run bit and flag.
// - clock-out toggles the pin on each overflow and suppresses the interrupt.
// - capture copies the count to the reload pair and sets external flag.
// - third timer request is overflow flag OR external flag, the latter outside up/down mode.
// - up-only mode reloads on overflow or enabled trigger edge.
// - up/down direction follows trigger pin; overflow toggles external flag.
// - down overflow loads all ones, up overflow loads the reload pair (zero in capture mode).
// - baud mode reloads without overflow flag; trigger only sets external flag.
// - baud rate is oscillator over 32 times (65536 minus reload).
// - count pins are sampled each machine cycle; a 1 then 0 counts.
// - machine cycle is 12 clocks, or 6 in 6T configuration.
// - down count enable lets the third timer count down.
module triple_timer_counter_baud #(
	parameter int MC_LONG  = 12,
	parameter int MC_SHORT = 6
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic [31:0]        hrdata,
	output logic               hresp,
	input  wire tt_pkg::pin_in_t pins,
	output logic               t0_irq,
	output logic               t1_irq,
	output logic               t3_irq,
	output logic               rx_clock_tick,
	output logic               tx_clock_tick,
	output logic               clock_out_pin
);
	import tt_pkg::*;

	if (MC_LONG < 2 || MC_LONG > 16 || MC_SHORT < 2 || MC_SHORT > 16)
		$error("machine cycle lengths must lie in 2..16");

	localparam logic [3:0] LAST_LONG  = 4'(MC_LONG - 1);
	localparam logic [3:0] LAST_SHORT = 4'(MC_SHORT - 1);

	lctl_t       ctl0_reg, ctl1_reg;
	t2ctl_t      t2c_reg;
	logic [1:0]  t2mod_reg;
	logic [3:0]  tctrl_reg;
	logic        six_t_reg;
	logic [15:0] cnt0_reg, cnt1_reg, cnt3_reg, reload_reg;
	logic [3:0]  pre_reg;
	logic        tick, half_reg;
	pin_in_t     smp_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;

	// Mode 0 keeps the upper three low-byte bits untouched.
	function automatic logic [16:0] lstep(input logic [15:0] c,
			input lmode_t m);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0]  s8;
		s13 = {1'b0, c[15:8], c[4:0]} + 14'd1;
		s16 = {1'b0, c} + 17'd1;
		s8  = {1'b0, c[7:0]} + 9'd1;
		unique case (m)
			m13:       lstep = {s13[13], s13[12:5], c[7:5], s13[4:0]};
			m16:       lstep = s16;
			m8_reload: lstep = {s8[8], c[15:8],
				s8[8] ? c[15:8] : s8[7:0]};
			m_split:   lstep = {s8[8], c[15:8], s8[7:0]};
		endcase
	endfunction : lstep

	// The tick is an argument, so assignments that call this follow it.
	function automatic logic gated(input lctl_t c, input logic run,
			input logic pin_int, input logic fall, input logic mc);
		gated = run && (!c.gate || pin_int)
			&& (c.count_select ? fall : mc);
	endfunction : gated

	// Machine-cycle enable from the bus clock, taken as the oscillator.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pre_reg <= '0;
		else if (tick)
			pre_reg <= '0;
		else
			pre_reg <= pre_reg + 4'd1;
	end
	assign tick = pre_reg == (six_t_reg ? LAST_SHORT : LAST_LONG);

	// Half-rate enable drives baud and clock-out counting.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			half_reg <= 1'b0;
		else
			half_reg <= !half_reg;
	end

	// Pins are sampled once per machine cycle; a 1 then 0 is an edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			smp_reg <= '0;
		else if (tick)
			smp_reg <= pins;
	end
	logic fall0, fall1, fall3, trig_fall;
	assign fall0     = tick && smp_reg.count0 && !pins.count0;
	assign fall1     = tick && smp_reg.count1 && !pins.count1;
	assign fall3     = tick && smp_reg.t3_count_pin && !pins.t3_count_pin;
	assign trig_fall = tick && smp_reg.trigger_pin
		&& !pins.trigger_pin;

	// Bus: address phase captured, write committed in the data phase.
	logic addr_ok, wr;
	assign addr_ok = hsel && htrans[1] && hready;
	assign wr      = wr_pend_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else begin
			wr_pend_reg <= addr_ok && hwrite;
			if (addr_ok)
				wr_addr_reg <= haddr[7:0];
		end
	end
	function automatic logic wr_to(input logic [7:0] a);
		wr_to = wr && wr_addr_reg == a;
	endfunction : wr_to

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl0_reg  <= '0;
			ctl1_reg  <= '0;
			t2mod_reg <= '0;
			six_t_reg <= 1'b0;
		end else begin
			if (wr_to(`A_TMODE)) begin
				ctl0_reg <= hwdata[3:0];
				ctl1_reg <= hwdata[7:4];
			end
			if (wr_to(`A_T2MOD))
				t2mod_reg <= hwdata[1:0];
			if (wr_to(`A_CFG))
				six_t_reg <= hwdata[`CFG_6T];
		end
	end

	// Legacy timers.
	logic [16:0] s0, s1;
	logic        t0_en, t1_en, th0_en, split0, run1_eff;
	logic        ovf0, ovf1, ovf_th0;
	logic [15:0] cnt0_next;
	assign split0   = ctl0_reg.mode == m_split;
	assign run1_eff = split0 || tctrl_reg[`TC_RUN1];
	assign s0       = lstep(cnt0_reg, ctl0_reg.mode);
	assign s1       = lstep(cnt1_reg, ctl1_reg.mode);
	assign t0_en    = gated(ctl0_reg, tctrl_reg[`TC_RUN0], pins.ext_int0,
		fall0, tick);
	// Timer 1 loses its run bit to the split high byte of timer 0.
	assign t1_en    = ctl1_reg.mode != m_split
		&& gated(ctl1_reg, run1_eff, pins.ext_int1, fall1, tick);
	assign th0_en   = split0 && tick && tctrl_reg[`TC_RUN1];
	assign ovf0     = t0_en && s0[16];
	assign ovf1     = t1_en && s1[16];
	assign ovf_th0  = th0_en && (&cnt0_reg[15:8]);
	always_comb begin
		cnt0_next = cnt0_reg;
		if (t0_en)
			cnt0_next = s0[15:0];
		if (split0)
			cnt0_next[15:8] = cnt0_reg[15:8] + {7'd0, th0_en};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt0_reg <= '0;
			cnt1_reg <= '0;
		end else begin
			cnt0_reg <= wr_to(`A_CNT0) ? hwdata[15:0] : cnt0_next;
			if (wr_to(`A_CNT1))
				cnt1_reg <= hwdata[15:0];
			else if (t1_en)
				cnt1_reg <= s1[15:0];
		end
	end

	// Run bits and flags; a hardware set wins over a software clear.
	logic tf1_set;
	assign tf1_set = split0 ? ovf_th0 : ovf1;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tctrl_reg <= '0;
		end else begin
			if (wr_to(`A_TCTRL))
				tctrl_reg <= hwdata[3:0];
			if (ovf0)
				tctrl_reg[`TC_OVF0] <= 1'b1;
			if (tf1_set)
				tctrl_reg[`TC_OVF1] <= 1'b1;
		end
	end

	// Third timer.
	t3mode_t     mode3;
	logic        serial_sel, clk_out, up, t3_en, trig, ovf_up, ovf_dn;
	logic        ovf3;
	logic [15:0] cnt3_next;
	assign serial_sel = t2c_reg.rx_clock_select || t2c_reg.tx_clock_select;
	assign clk_out    = t2mod_reg[`M2_OE] && !t2c_reg.t3_count_select;
	always_comb begin
		if (!t2c_reg.t3_run)
			mode3 = t3_off;
		else if (serial_sel)
			mode3 = baud_generator_mode;
		else if (t2c_reg.capture_reload_select)
			mode3 = capture_mode;
		else if (t2mod_reg[`M2_DOWN_COUNT_ENABLE])
			mode3 = reload_up_down_mode;
		else
			mode3 = reload_up_only_mode;
	end
	// Baud and clock-out count at half the oscillator, which gives the
	// divide by 32 once the serial port divides the tick by 16.
	assign t3_en = mode3 != t3_off && (t2c_reg.t3_count_select ? fall3
		: ((serial_sel || clk_out) ? half_reg : tick));
	assign up    = mode3 != reload_up_down_mode
		|| pins.trigger_pin;
	assign trig  = trig_fall && t2c_reg.trigger_enable
		&& mode3 != t3_off;
	assign ovf_up = t3_en && up && (&cnt3_reg);
	// Counting down, the overflow is reaching the reload value.
	assign ovf_dn = t3_en && !up && cnt3_reg == reload_reg;
	assign ovf3   = ovf_up || ovf_dn;
	always_comb begin
		cnt3_next = cnt3_reg;
		if (ovf_dn)
			cnt3_next = `DOWN_LOAD;
		else if (ovf_up)
			cnt3_next = mode3 == capture_mode ? '0 : reload_reg;
		else if (trig && mode3 == reload_up_only_mode)
			cnt3_next = reload_reg;
		else if (t3_en)
			cnt3_next = up ? cnt3_reg + 16'd1 : cnt3_reg - 16'd1;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt3_reg   <= '0;
			reload_reg <= '0;
		end else begin
			cnt3_reg <= wr_to(`A_CNT3) ? hwdata[15:0] : cnt3_next;
			if (wr_to(`A_RELOAD))
				reload_reg <= hwdata[15:0];
			else if (trig && mode3 == capture_mode)
				reload_reg <= cnt3_reg;
		end
	end

	// Third timer flags; software clears them, and the up/down overflow toggle can also clear the external flag.
	t2ctl_t t2c_next;
	logic   tf3_set, exf3_set, exf3_tgl;
	assign tf3_set  = ovf3 && !serial_sel && !clk_out;
	assign exf3_set = trig && mode3 != reload_up_down_mode;
	assign exf3_tgl = ovf3 && mode3 == reload_up_down_mode;
	always_comb begin
		t2c_next = wr_to(`A_T2CTL) ? t2ctl_t'(hwdata[7:0]) : t2c_reg;
		if (tf3_set)
			t2c_next.t3_overflow_flag = 1'b1;
		if (exf3_set)
			t2c_next.t3_external_flag = 1'b1;
		else if (exf3_tgl)
			t2c_next.t3_external_flag = !t2c_next.t3_external_flag;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			t2c_reg <= '0;
			t3_irq  <= 1'b0;
			t0_irq  <= 1'b0;
			t1_irq  <= 1'b0;
		end else begin
			t2c_reg <= t2c_next;
			t3_irq  <= t2c_next.t3_overflow_flag
				|| (t2c_next.t3_external_flag
				&& mode3 != reload_up_down_mode);
			t0_irq  <= tctrl_reg[`TC_OVF0];
			t1_irq  <= tctrl_reg[`TC_OVF1];
		end
	end

	// Serial ticks carry raw overflow pulses to the serial port.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_clock_tick <= 1'b0;
			tx_clock_tick <= 1'b0;
			clock_out_pin <= 1'b0;
		end else begin
			rx_clock_tick <= t2c_reg.rx_clock_select ? ovf3 : ovf1;
			tx_clock_tick <= t2c_reg.tx_clock_select ? ovf3 : ovf1;
			if (clk_out && ovf3)
				clock_out_pin <= !clock_out_pin;
		end
	end

	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		unique case (a)
			`A_TMODE:  rd_mux = {24'd0, ctl1_reg, ctl0_reg};
			`A_TCTRL:  rd_mux = {28'd0, tctrl_reg};
			`A_T2CTL:  rd_mux = {24'd0, t2c_reg};
			`A_T2MOD:  rd_mux = {30'd0, t2mod_reg};
			`A_CNT0:   rd_mux = {16'd0, cnt0_reg};
			`A_CNT1:   rd_mux = {16'd0, cnt1_reg};
			`A_CNT3:   rd_mux = {16'd0, cnt3_reg};
			`A_RELOAD: rd_mux = {16'd0, reload_reg};
			`A_CFG:    rd_mux = {31'd0, six_t_reg};
			default:   rd_mux = '0;
		endcase
	endfunction : rd_mux

	// Read data is registered at the address phase: zero wait states.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ok && !hwrite)
				hrdata <= rd_mux(haddr[7:0]);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_tick_gap;
		!tick [*5];
	endsequence
	sequence s_capture;
		mode3 == capture_mode && trig && !wr;
	endsequence

	a_tf3_serial_block:
	assert property (serial_sel && !wr |=> !$rose(t2c_reg.t3_overflow_flag))
		else $error("overflow flag set while serial clock selected");
	a_trig_disabled:
	assert property (!t2c_reg.trigger_enable && !wr
		&& mode3 != reload_up_down_mode
		|=> $stable(t2c_reg.t3_external_flag))
		else $error("external flag moved with trigger disabled");
	a_capture_copy:
	assert property (s_capture |=> reload_reg == $past(cnt3_reg)
		&& t2c_reg.t3_external_flag)
		else $error("capture did not copy count");
	a_down_load_ones:
	assert property (ovf_dn && !wr |=> cnt3_reg == `DOWN_LOAD)
		else $error("down overflow did not load all ones");
	a_irq_or_flags:
	assert property (##1 t3_irq == (t2c_reg.t3_overflow_flag
		|| (t2c_reg.t3_external_flag
		&& $past(mode3) != reload_up_down_mode)))
		else $error("timer request is not the flag OR");
	a_tick_spacing:
	assert property (tick |=> s_tick_gap)
		else $error("machine cycle shorter than six clocks");
	a_clock_out_toggle:
	assert property (clk_out && ovf3 |=> clock_out_pin
		!= $past(clock_out_pin))
		else $error("clock output did not toggle");
	a_rx_independent:
	assert property (t2c_reg.rx_clock_select && !t2c_reg.tx_clock_select
		&& ovf1 && !ovf3 |=> tx_clock_tick && !rx_clock_tick)
		else $error("serial clock selections not independent");
	a_mode2_reload:
	assert property (ctl1_reg.mode == m8_reload && ovf1 && !wr
		|=> cnt1_reg[7:0] == $past(cnt1_reg[15:8]))
		else $error("mode 2 did not reload low byte");
	a_gate_hold:
	assert property (ctl0_reg.gate && !pins.ext_int0 && !split0 && !wr
		|=> cnt0_reg == $past(cnt0_reg))
		else $error("gated timer counted");
endmodule : triple_timer_counter_baud

/* triple_timer_counter_baud_tb.sv */
// Self-checking bench for the triple timer/counter block.
`timescale 1ns/1ps
`include "tt_map.svh"
module triple_timer_counter_baud_tb;
	import tt_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	pin_in_t     want, pins;
	logic        t0_irq, t1_irq, t3_irq;
	logic        rx_clock_tick, tx_clock_tick, clock_out_pin;
	int          num_errors, num_checks, n_rx, n_tx, n_out;

	assign hready = hreadyout;

	triple_timer_counter_baud u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .pins(pins), .t0_irq(t0_irq),
		.t1_irq(t1_irq), .t3_irq(t3_irq), .rx_clock_tick(rx_clock_tick),
		.tx_clock_tick(tx_clock_tick), .clock_out_pin(clock_out_pin)
	);

	pin_model u_pins (.hclk(hclk), .hresetn(hresetn), .want(want),
		.pins(pins));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Ticks are far apart, so counting rising edges loses no pulse.
	always @(posedge rx_clock_tick) n_rx++;
	always @(posedge tx_clock_tick) n_tx++;
	always @(clock_out_pin) n_out++;

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_in(input logic [31:0] got, lo, hi);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h..%h", $time, got,
				lo, hi);
		end
	endtask : chk_in

	// The slave answers with no wait states, but the loops still wait on
	// hready so a slower slave would not break the sequence.
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h00, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rdc

	task automatic rdr(input logic [7:0] a, input logic [31:0] lo, hi);
		bus(1'b0, a, 32'h0);
		chk_in(q, lo, hi);
	endtask : rdr

	task automatic wait_clk(input int n);
		repeat (n) @(posedge hclk);
	endtask : wait_clk

	function automatic logic irq(input int k);
		return k == 0 ? t0_irq : k == 1 ? t1_irq : t3_irq;
	endfunction : irq

	task automatic wait_irq(input int k, input int n);
		for (int i = 0; i < n && irq(k) !== 1'b1; i++)
			@(posedge hclk);
		chk({31'h0, irq(k)}, 32'h1);
	endtask : wait_irq

	// Each level is held 30 clocks, longer than two machine cycles.
	task automatic pulse(input logic [5:0] m);
		want <= want & ~m;
		wait_clk(30);
		want <= want | m;
		wait_clk(30);
	endtask : pulse

	task automatic s_regs();
		rdc(`A_T2CTL, 32'h0);
		wr(8'h40, 32'h5a);
		rdc(8'h40, 32'h0);
		wr(`A_RELOAD, 32'h1234);
		rdc(`A_RELOAD, 32'h1234);
	endtask : s_regs

	task automatic s_legacy();
		want.ext_int0 <= 1'b0;
		wr(`A_TMODE, 32'h08);
		wr(`A_CNT0, 32'hff1f);
		wr(`A_TCTRL, 32'h01);
		wait_clk(60);
		rdc(`A_CNT0, 32'hff1f);
		want.ext_int0 <= 1'b1;
		wait_irq(0, 40);
		rdr(`A_CNT0, 32'h0, 32'h2);
		wr(`A_TCTRL, 32'h0);
		wr(`A_TMODE, 32'h02);
		wr(`A_CNT0, 32'hf0fe);
		wr(`A_TCTRL, 32'h01);
		wait_irq(0, 60);
		rdr(`A_CNT0, 32'hf0f0, 32'hf0f2);
		wr(`A_TCTRL, 32'h0);
	endtask : s_legacy

	task automatic s_timer1();
		wr(`A_TMODE, 32'h10);
		wr(`A_CNT1, 32'hfffe);
		n_rx = 0;
		n_tx = 0;
		wr(`A_TCTRL, 32'h02);
		wait_irq(1, 60);
		rdr(`A_CNT1, 32'h0, 32'h2);
		chk(32'(n_rx), 32'h1);
		chk(32'(n_tx), 32'h1);
		wr(`A_TMODE, 32'h30);
		bus(1'b0, `A_CNT1, 32'h0);
		wait_clk(50);
		rdc(`A_CNT1, q);
		wr(`A_TCTRL, 32'h0);
		wr(`A_TMODE, 32'h0);
	endtask : s_timer1

	// Timer 1 reloads every four machine cycles and feeds the other
	// serial direction, so both sources run side by side.
	task automatic s_baud();
		wr(`A_TMODE, 32'h20);
		wr(`A_CNT1, 32'hfcfc);
		wr(`A_TCTRL, 32'h02);
		wr(`A_RELOAD, 32'hfff0);
		wr(`A_CNT3, 32'hfff0);
		wr(`A_T2CTL, 32'h24);
		n_rx = 0;
		n_tx = 0;
		wait_clk(320);
		chk_in(32'(n_rx), 32'h9, 32'hb);
		chk_in(32'(n_tx), 32'h6, 32'h7);
		rdc(`A_T2CTL, 32'h24);
		wr(`A_T2CTL, 32'h2c);
		pulse(6'h04);
		rdc(`A_T2CTL, 32'h6c);
		chk({31'h0, t3_irq}, 32'h1);
		wr(`A_T2CTL, 32'h14);
		n_rx = 0;
		n_tx = 0;
		wait_clk(320);
		chk_in(32'(n_tx), 32'h9, 32'hb);
		chk_in(32'(n_rx), 32'h6, 32'h7);
		wr(`A_T2CTL, 32'h0);
		wr(`A_TCTRL, 32'h0);
		wr(`A_TMODE, 32'h0);
	endtask : s_baud

	// In the short machine cycle timer 0 counts once every six clocks.
	task automatic s_six_t();
		wr(`A_TMODE, 32'h01);
		wr(`A_CNT0, 32'h0);
		wr(`A_CFG, 32'h01);
		wr(`A_TCTRL, 32'h01);
		wait_clk(120);
		rdr(`A_CNT0, 32'h13, 32'h15);
		wr(`A_TCTRL, 32'h0);
		wr(`A_CFG, 32'h0);
		wr(`A_TMODE, 32'h0);
	endtask : s_six_t

	task automatic s_capture();
		wr(`A_RELOAD, 32'h0);
		wr(`A_CNT3, 32'h1000);
		wr(`A_T2CTL, 32'h05);
		pulse(6'h04);
		rdc(`A_RELOAD, 32'h0);
		rdc(`A_T2CTL, 32'h05);
		wr(`A_T2CTL, 32'h0d);
		pulse(6'h04);
		rdc(`A_T2CTL, 32'h4d);
		chk({31'h0, t3_irq}, 32'h1);
		rdr(`A_RELOAD, 32'h1000, 32'h1040);
		wr(`A_T2CTL, 32'h0d);
		wait_clk(2);
		chk({31'h0, t3_irq}, 32'h0);
		wr(`A_RELOAD, 32'h4000);
		wr(`A_CNT3, 32'h0100);
		wr(`A_T2CTL, 32'h0c);
		pulse(6'h04);
		rdc(`A_T2CTL, 32'h4c);
		rdr(`A_CNT3, 32'h4000, 32'h4008);
		wr(`A_T2CTL, 32'h06);
		wr(`A_CNT3, 32'h0);
		for (int i = 0; i < 5; i++)
			pulse(6'h08);
		rdc(`A_CNT3, 32'h5);
		wr(`A_T2CTL, 32'h0);
	endtask : s_capture

	task automatic s_updown();
		wr(`A_T2MOD, 32'h01);
		wr(`A_RELOAD, 32'h0010);
		wr(`A_CNT3, 32'h0014);
		want.trigger_pin <= 1'b0;
		wait_clk(30);
		wr(`A_T2CTL, 32'h04);
		wait_irq(2, 100);
		rdr(`A_CNT3, 32'hfff8, 32'hffff);
		rdc(`A_T2CTL, 32'hc4);
		wr(`A_T2CTL, 32'h44);
		wait_clk(2);
		chk({31'h0, t3_irq}, 32'h0);
		wr(`A_T2CTL, 32'h0);
		want.trigger_pin <= 1'b1;
		wait_clk(30);
		wr(`A_CNT3, 32'hfffe);
		wr(`A_T2CTL, 32'h04);
		wait_irq(2, 60);
		rdr(`A_CNT3, 32'h0010, 32'h0014);
		rdc(`A_T2CTL, 32'hc4);
		wr(`A_T2CTL, 32'h0);
		wr(`A_T2MOD, 32'h0);
	endtask : s_updown

	task automatic s_clkout();
		wr(`A_T2MOD, 32'h02);
		wr(`A_RELOAD, 32'hfff0);
		wr(`A_CNT3, 32'hfff0);
		wr(`A_T2CTL, 32'h04);
		n_out = 0;
		wait_clk(320);
		chk_in(32'(n_out), 32'h9, 32'hb);
		rdc(`A_T2CTL, 32'h04);
		chk({31'h0, t3_irq}, 32'h0);
		wr(`A_T2CTL, 32'h0);
		bus(1'b0, `A_CNT3, 32'h0);
		wait_clk(40);
		rdc(`A_CNT3, q);
		wr(`A_T2MOD, 32'h0);
	endtask : s_clkout

	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		want = '1;
		hresetn = 1'b0;
		num_errors = 0;
		num_checks = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		s_regs();
		s_legacy();
		s_timer1();
		s_baud();
		s_capture();
		s_updown();
		s_clkout();
		s_six_t();
		report_and_stop();
	end

	// The scenarios take about 2200 clocks; nine times that means a hang.
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		report_and_stop();
	end
endmodule : triple_timer_counter_baud_tb

/* tt_map.svh */
// Register offsets, bit positions and constants of the timer block.
`ifndef TT_MAP_SVH
`define TT_MAP_SVH
`define A_TMODE   8'h00
`define A_TCTRL   8'h04
`define A_T2CTL   8'h08
`define A_T2MOD   8'h0c
`define A_CNT0    8'h10
`define A_CNT1    8'h14
`define A_CNT3    8'h18
`define A_RELOAD  8'h1c
`define A_CFG     8'h20
`define TC_RUN0   0
`define TC_RUN1   1
`define TC_OVF0   2
`define TC_OVF1   3
`define M2_DOWN_COUNT_ENABLE   0
`define M2_OE     1
`define CFG_6T    0
`define DOWN_LOAD 16'hffff
`endif

/* tt_pkg.sv */
// Types shared by the triple timer/counter block.
package tt_pkg;
	typedef enum logic [1:0] {m13, m16, m8_reload, m_split} lmode_t;
	typedef struct packed {
		logic   gate;
		logic   count_select;
		lmode_t mode;
	} lctl_t;
	typedef struct packed {
		logic t3_overflow_flag;
		logic t3_external_flag;
		logic rx_clock_select;
		logic tx_clock_select;
		logic trigger_enable;
		logic t3_run;
		logic t3_count_select;
		logic capture_reload_select;
	} t2ctl_t;
	typedef enum logic [2:0] {
		t3_off,
		baud_generator_mode,
		capture_mode,
		reload_up_only_mode,
		reload_up_down_mode
	} t3mode_t;
	typedef struct packed {
		logic count0;
		logic count1;
		logic t3_count_pin;
		logic trigger_pin;
		logic ext_int0;
		logic ext_int1;
	} pin_in_t;
endpackage : tt_pkg
